// ==== design/htr_readout.sv ====
/*
  Command and readout logic of a humidity/temperature sensor acting as a
  target on a two-wire serial bus: power-up, command reception with
  checksums, single-shot and periodic acquisition, result readout.
  Assumes scl_in, sda_in and supply_ok are asynchronous pins; temp_sample
  and hum_sample come from the converter on this clock. The pad combines
  sda_out and sda_oe as an open-drain driver.
*/
`include "htr_consts.svh"

module htr_readout #(
  parameter logic [6:0]  DEV_ADDR   = `HTR_DEV_ADDR,
  parameter int unsigned PU_CYC     = `HTR_POWER_UP_US * `HTR_CYC_PER_US,
  parameter int unsigned CONV_L_CYC = `HTR_CONV_LOW_US * `HTR_CYC_PER_US,
  parameter int unsigned CONV_M_CYC = `HTR_CONV_MED_US * `HTR_CYC_PER_US,
  parameter int unsigned CONV_H_CYC = `HTR_CONV_HIGH_US * `HTR_CYC_PER_US,
  parameter int unsigned PER0_CYC   = `HTR_PER_0P5_MS * `HTR_CYC_PER_MS,
  parameter int unsigned PER1_CYC   = `HTR_PER_1_MS * `HTR_CYC_PER_MS,
  parameter int unsigned PER2_CYC   = `HTR_PER_2_MS * `HTR_CYC_PER_MS,
  parameter int unsigned PER3_CYC   = `HTR_PER_4_MS * `HTR_CYC_PER_MS,
  parameter int unsigned PER4_CYC   = `HTR_PER_10_MS * `HTR_CYC_PER_MS,
  parameter int          FIFO_DEPTH = 16
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        supply_ok,
  input  wire logic [15:0] temp_sample,
  input  wire logic [15:0] hum_sample,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             ready,
  output logic             measuring,
  output logic             periodic_mode,
  output logic             low_power_idle,
  output logic [15:0]      wr_data,
  output logic             wr_valid
);

  localparam int CW = 26;                      // Timing counter width
  localparam int LW = $clog2(FIFO_DEPTH + 1);  // FIFO level width

  // Data word checksum, MSB first
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = `HTR_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ `HTR_CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // Command word check: folded 3-bit checksum and legal fields
  function automatic logic cmd_ok(input logic [15:0] w);
    logic [2:0] c;
    logic [7:0] cls;
    c   = 3'h0;
    cls = w[`HTR_CMD_CLS_HI:`HTR_CMD_CLS_LO];
    for (int i = 0; i < 13; i++) begin
      c[i % 3] = c[i % 3] ^ w[i + 3];
    end
    return (c == w[`HTR_CMD_CHK_HI:`HTR_CMD_CHK_LO])
      && (cls == `HTR_CLS_SINGLE || cls == `HTR_CLS_PERIODIC || cls == `HTR_CLS_BREAK)
      && (w[`HTR_CMD_REP_HI:`HTR_CMD_REP_LO] <= `HTR_REP_MAX)
      && (w[`HTR_CMD_RATE_HI:`HTR_CMD_RATE_LO] <= `HTR_RATE_MAX);
  endfunction

  // Readout byte by index: T hi, T lo, T crc, H hi, H lo, H crc
  function automatic logic [7:0] tx_byte(input logic [2:0] i, input logic [15:0] t,
                                         input logic [15:0] h);
    case (i)
      3'h0:    return t[15:8];
      3'h1:    return t[7:0];
      3'h2:    return crc8(t);
      3'h3:    return h[15:8];
      3'h4:    return h[7:0];
      default: return crc8(h);
    endcase
  endfunction

  // Conversion length by repeatability
  function automatic logic [CW-1:0] conv_lim(input logic [1:0] r);
    case (r)
      2'h0:    return CW'(CONV_L_CYC - 1);
      2'h1:    return CW'(CONV_M_CYC - 1);
      default: return CW'(CONV_H_CYC - 1);
    endcase
  endfunction

  // Acquisition period by rate code
  function automatic logic [CW-1:0] per_lim(input logic [2:0] r);
    case (r)
      3'h0:    return CW'(PER0_CYC - 1);
      3'h1:    return CW'(PER1_CYC - 1);
      3'h2:    return CW'(PER2_CYC - 1);
      3'h3:    return CW'(PER3_CYC - 1);
      default: return CW'(PER4_CYC - 1);
    endcase
  endfunction

  logic [2:0]        pin_s;      // Synchronised {supply, sda, scl}
  logic              scl_s;
  logic              sda_s;
  logic              sup_s;
  logic              scl_d_ff;   // Previous synchronised clock
  logic              sda_d_ff;   // Previous synchronised data
  logic              rise;
  logic              fall;
  logic              start_ev;
  logic              stop_ev;

  htr_sync #(.W(3), .RST_VAL(3'h3)) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({supply_ok, sda_in, scl_in}),
    .q     (pin_s)
  );
  assign scl_s = pin_s[0];
  assign sda_s = pin_s[1];
  assign sup_s = pin_s[2];

  // Bus condition detection on synchronised pins
  assign rise     = scl_s & ~scl_d_ff;
  assign fall     = ~scl_s & scl_d_ff;
  assign start_ev = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_ev  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // FIFO ties
  logic              f_in_valid;
  logic              f_in_ready;
  logic [15:0]       f_in_data;
  logic              f_pop;
  logic [15:0]       f_out_data;
  logic [LW-1:0]     f_level;
  logic              room2;      // Space for a whole pair

  // Power-up group
  logic [CW-1:0]     pu_ff;
  logic              ready_ff;
  logic [CW-1:0]     nxt_pu;
  logic              nxt_ready;

  // Power-up timer: idle is reached a full delay after supply is good
  always_comb begin
    nxt_pu    = pu_ff;
    nxt_ready = ready_ff;
    if (!sup_s) begin
      nxt_pu    = '0;
      nxt_ready = 1'b0;
    end else if (!ready_ff) begin
      if (pu_ff == CW'(PU_CYC - 1)) begin
        nxt_ready = 1'b1;
      end else begin
        nxt_pu = pu_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pu_ff    <= '0;
      ready_ff <= 1'b0;
    end else begin
      pu_ff    <= nxt_pu;
      ready_ff <= nxt_ready;
    end
  end

  // Bus group
  htr_pkg::htr_bus_e bus_ff, nxt_bus;
  logic [3:0]        bit_ff, nxt_bit;     // Bit count within a byte
  logic [7:0]        sh_ff, nxt_sh;       // Shift register
  logic [2:0]        byte_ff, nxt_byte;   // Byte number in a write
  logic              rd_ff, nxt_rd;       // Transfer is a read
  logic [2:0]        idx_ff, nxt_idx;     // Readout byte index
  logic              oe_ff, nxt_oe;       // Pulls data line low
  logic [15:0]       cmd_ff, nxt_cmd;     // Received command word
  logic [15:0]       wdat_ff, nxt_wdat;   // Written data word
  logic [15:0]       t_ff, nxt_t;         // Temperature being sent
  logic [15:0]       h_ff, nxt_h;         // Humidity being sent
  logic              fetch_ff, nxt_fetch; // Second word pop pending
  logic              go_ff, nxt_go;       // Valid command pulse
  logic              wrv_ff, nxt_wrv;     // Data write accepted pulse
  logic [15:0]       wacc_ff, nxt_wacc;   // Kept data word
  logic              ack;
  logic [7:0]        tx_b;

  assign tx_b = tx_byte(idx_ff, t_ff, h_ff);

  // Target protocol engine
  always_comb begin
    nxt_bus = bus_ff;   nxt_bit = bit_ff;   nxt_sh = sh_ff;   nxt_byte = byte_ff;
    nxt_rd = rd_ff;     nxt_idx = idx_ff;   nxt_oe = oe_ff;   nxt_cmd = cmd_ff;
    nxt_wdat = wdat_ff; nxt_t = t_ff;       nxt_h = h_ff; nxt_wacc = wacc_ff;
    nxt_fetch = 1'b0;   nxt_go = 1'b0;      nxt_wrv = 1'b0;   ack = 1'b0;
    f_pop = 1'b0;
    // Second result word follows one cycle after the first pop
    if (fetch_ff) begin
      f_pop = 1'b1;
      nxt_h = f_out_data;
    end
    if (start_ev) begin
      nxt_bus  = htr_pkg::HTR_B_RX;
      nxt_bit  = 4'h0;
      nxt_byte = 3'h0;
      nxt_oe   = 1'b0;
    end else if (stop_ev) begin
      nxt_bus = htr_pkg::HTR_B_IDLE;
      nxt_oe  = 1'b0;
    end else begin
      case (bus_ff)
        htr_pkg::HTR_B_RX: begin
          if (rise) begin
            nxt_sh  = {sh_ff[6:0], sda_s};
            nxt_bit = bit_ff + 4'h1;
          end else if (fall && bit_ff == 4'h8) begin
            nxt_bit = 4'h0;
            case (byte_ff)
              3'h0: begin
                nxt_rd = sh_ff[0];
                if (sh_ff[7:1] == DEV_ADDR && ready_ff) begin
                  if (!sh_ff[0]) begin
                    ack = 1'b1;
                  end else if (f_level >= LW'(2)) begin
                    ack       = 1'b1;
                    f_pop     = 1'b1;
                    nxt_t     = f_out_data;
                    nxt_fetch = 1'b1;
                    nxt_idx   = 3'h0;
                  end
                end
              end
              3'h1: begin
                nxt_cmd[15:8] = sh_ff;
                ack           = 1'b1;
              end
              3'h2: begin
                nxt_cmd[7:0] = sh_ff;
                ack          = cmd_ok({cmd_ff[15:8], sh_ff});
                nxt_go       = ack;
              end
              3'h3: begin
                nxt_wdat[15:8] = sh_ff;
                ack            = 1'b1;
              end
              3'h4: begin
                nxt_wdat[7:0] = sh_ff;
                ack           = 1'b1;
              end
              `HTR_LAST_WR_BYTE: begin
                ack     = (crc8(wdat_ff) == sh_ff);
                nxt_wrv = ack;
                nxt_wacc = ack ? wdat_ff : wacc_ff;
              end
              default: ack = 1'b0;
            endcase
            nxt_oe  = ack;
            nxt_bus = ack ? htr_pkg::HTR_B_ACK : htr_pkg::HTR_B_SKIP;
          end
        end
        htr_pkg::HTR_B_ACK: begin
          if (fall) begin
            nxt_bit = 4'h0;
            if (rd_ff) begin
              nxt_sh  = tx_b;
              nxt_oe  = ~tx_b[7];
              nxt_bus = htr_pkg::HTR_B_TX;
            end else begin
              nxt_oe   = 1'b0;
              nxt_byte = byte_ff + 3'h1;
              nxt_bus  = htr_pkg::HTR_B_RX;
            end
          end
        end
        htr_pkg::HTR_B_TX: begin
          if (fall) begin
            if (bit_ff == 4'h7) begin
              nxt_oe  = 1'b0;
              nxt_bit = 4'h0;
              nxt_bus = htr_pkg::HTR_B_TXACK;
            end else begin
              nxt_sh  = {sh_ff[6:0], 1'b0};
              nxt_oe  = ~sh_ff[6];
              nxt_bit = bit_ff + 4'h1;
            end
          end
        end
        htr_pkg::HTR_B_TXACK: begin
          if (rise) begin
            if (!sda_s && idx_ff != `HTR_LAST_TX_IDX) begin
              nxt_idx = idx_ff + 3'h1;
              nxt_bus = htr_pkg::HTR_B_TXNEXT;
            end else begin
              nxt_bus = htr_pkg::HTR_B_SKIP;
            end
          end
        end
        htr_pkg::HTR_B_TXNEXT: begin
          if (fall) begin
            nxt_sh  = tx_b;
            nxt_oe  = ~tx_b[7];
            nxt_bus = htr_pkg::HTR_B_TX;
          end
        end
        htr_pkg::HTR_B_IDLE, htr_pkg::HTR_B_SKIP: nxt_oe = 1'b0;
        default: nxt_bus = htr_pkg::HTR_B_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bus_ff <= htr_pkg::HTR_B_IDLE; bit_ff <= 4'h0;  sh_ff <= 8'h00;   byte_ff <= 3'h0;
      rd_ff <= 1'b0;    idx_ff <= 3'h0;   oe_ff <= 1'b0;  cmd_ff <= 16'h0000;
      wdat_ff <= 16'h0000; t_ff <= 16'h0000; h_ff <= 16'h0000; fetch_ff <= 1'b0;
      go_ff <= 1'b0;    wrv_ff <= 1'b0;   scl_d_ff <= 1'b1; sda_d_ff <= 1'b1; wacc_ff <= 16'h0000;
    end else begin
      bus_ff <= nxt_bus;   bit_ff <= nxt_bit;   sh_ff <= nxt_sh;   byte_ff <= nxt_byte;
      rd_ff <= nxt_rd;     idx_ff <= nxt_idx;   oe_ff <= nxt_oe;   cmd_ff <= nxt_cmd;
      wdat_ff <= nxt_wdat; t_ff <= nxt_t;       h_ff <= nxt_h;     fetch_ff <= nxt_fetch;
      go_ff <= nxt_go;     wrv_ff <= nxt_wrv;   scl_d_ff <= scl_s; sda_d_ff <= sda_s;
      wacc_ff <= nxt_wacc;
    end
  end

  // Measurement group
  htr_pkg::htr_meas_e m_ff, nxt_m;
  logic [CW-1:0]     conv_ff, nxt_conv;   // Conversion timer
  logic [CW-1:0]     per_ff, nxt_per;     // Period timer
  logic [1:0]        rep_ff, nxt_rep;     // Repeatability
  logic [2:0]        rate_ff, nxt_rate;   // Periodic rate code
  logic              pmode_ff, nxt_pmode; // Periodic mode active
  logic [7:0]        cls;

  assign cls        = cmd_ff[`HTR_CMD_CLS_HI:`HTR_CMD_CLS_LO];
  assign room2      = (f_level <= LW'(FIFO_DEPTH - 2));
  assign f_in_valid = (m_ff == htr_pkg::HTR_M_PUSH_T && room2 && !go_ff)
                   || (m_ff == htr_pkg::HTR_M_PUSH_H);
  assign f_in_data  = (m_ff == htr_pkg::HTR_M_PUSH_T) ? temp_sample : hum_sample;

  // Acquisition sequencer
  always_comb begin
    nxt_m = m_ff;  nxt_conv = conv_ff;  nxt_rep = rep_ff;  nxt_rate = rate_ff;
    nxt_pmode = pmode_ff;
    nxt_per = (pmode_ff && per_ff != '1) ? per_ff + 1'b1 : per_ff;
    if (!ready_ff) begin
      nxt_m     = htr_pkg::HTR_M_IDLE;
      nxt_pmode = 1'b0;
    end else if (go_ff) begin
      nxt_conv = '0;
      nxt_per  = '0;
      nxt_rep  = cmd_ff[`HTR_CMD_REP_HI:`HTR_CMD_REP_LO];
      nxt_rate = cmd_ff[`HTR_CMD_RATE_HI:`HTR_CMD_RATE_LO];
      if (cls == `HTR_CLS_BREAK) begin
        nxt_m     = htr_pkg::HTR_M_IDLE;
        nxt_pmode = 1'b0;
      end else begin
        nxt_m     = htr_pkg::HTR_M_CONV;
        nxt_pmode = (cls == `HTR_CLS_PERIODIC);
      end
    end else begin
      case (m_ff)
        htr_pkg::HTR_M_IDLE: nxt_m = htr_pkg::HTR_M_IDLE;
        htr_pkg::HTR_M_CONV: begin
          nxt_conv = conv_ff + 1'b1;
          if (conv_ff == conv_lim(rep_ff)) begin
            nxt_m = htr_pkg::HTR_M_PUSH_T;
          end
        end
        htr_pkg::HTR_M_PUSH_T: begin
          if (room2) begin
            nxt_m = htr_pkg::HTR_M_PUSH_H;
          end
        end
        htr_pkg::HTR_M_PUSH_H: begin
          nxt_m = pmode_ff ? htr_pkg::HTR_M_WAIT : htr_pkg::HTR_M_IDLE;
        end
        htr_pkg::HTR_M_WAIT: begin
          if (per_ff >= per_lim(rate_ff)) begin
            nxt_conv = '0;
            nxt_per  = '0;
            nxt_m    = htr_pkg::HTR_M_CONV;
          end
        end
        default: nxt_m = htr_pkg::HTR_M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      m_ff <= htr_pkg::HTR_M_IDLE; conv_ff <= '0; per_ff <= '0;
      rep_ff <= 2'h0; rate_ff <= 3'h0; pmode_ff <= 1'b0;
    end else begin
      m_ff <= nxt_m; conv_ff <= nxt_conv; per_ff <= nxt_per;
      rep_ff <= nxt_rep; rate_ff <= nxt_rate; pmode_ff <= nxt_pmode;
    end
  end

  htr_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (),
    .out_ready (f_pop),
    .out_data  (f_out_data),
    .level     (f_level)
  );

  // Status outputs
  logic meas_ff;
  logic lp_ff;
  logic nxt_meas;
  logic nxt_lp;

  // Busy and self-entered low-energy idle
  always_comb begin
    nxt_meas = (m_ff == htr_pkg::HTR_M_CONV) || (m_ff == htr_pkg::HTR_M_PUSH_T)
            || (m_ff == htr_pkg::HTR_M_PUSH_H);
    nxt_lp   = ready_ff && !nxt_meas && f_in_ready
            && (bus_ff == htr_pkg::HTR_B_IDLE);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      meas_ff <= 1'b0;
      lp_ff   <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      meas_ff <= nxt_meas;
      lp_ff   <= nxt_lp;
      sda_out <= 1'b0;
    end
  end

  assign sda_oe         = oe_ff;
  assign ready          = ready_ff;
  assign measuring      = meas_ff;
  assign periodic_mode  = pmode_ff;
  assign low_power_idle = lp_ff;
  assign wr_data        = wacc_ff;
  assign wr_valid       = wrv_ff;

endmodule

// ==== design/htr_consts.svh ====
/*
  Offsets-free constant set of the humidity/temperature readout: command
  field layout, codes, checksum seeds and timing figures.
  Assumes inclusion by bare name before any module that uses it.
*/
`ifndef HTR_CONSTS_SVH
`define HTR_CONSTS_SVH

// System clock rate in hertz
`define HTR_CLK_HZ        20000000
// Cycles per microsecond and per millisecond, derived from the rate
`define HTR_CYC_PER_US    (`HTR_CLK_HZ / 1000000)
`define HTR_CYC_PER_MS    (`HTR_CLK_HZ / 1000)

// Power-up delay, longest figure, in microseconds
`define HTR_POWER_UP_US   1500
// Longest conversion time per repeatability, in microseconds
`define HTR_CONV_LOW_US   4500
`define HTR_CONV_MED_US   6500
`define HTR_CONV_HIGH_US  15500
// Periodic acquisition period per rate code, in milliseconds
`define HTR_PER_0P5_MS    2000
`define HTR_PER_1_MS      1000
`define HTR_PER_2_MS      500
`define HTR_PER_4_MS      250
`define HTR_PER_10_MS     100

// Default bus address (arbitrary)
`define HTR_DEV_ADDR      7'h45

// Command word layout: class byte, repeatability, rate, checksum
`define HTR_CMD_CLS_HI    15
`define HTR_CMD_CLS_LO    8
`define HTR_CMD_REP_HI    7
`define HTR_CMD_REP_LO    6
`define HTR_CMD_RATE_HI   5
`define HTR_CMD_RATE_LO   3
`define HTR_CMD_CHK_HI    2
`define HTR_CMD_CHK_LO    0
// Command class codes (arbitrary)
`define HTR_CLS_SINGLE    8'hA4
`define HTR_CLS_PERIODIC  8'hB8
`define HTR_CLS_BREAK     8'hC3
// Highest legal repeatability and rate codes
`define HTR_REP_MAX       2'h2
`define HTR_RATE_MAX      3'h4

// Data checksum generator and seed
`define HTR_CRC_POLY      8'h07
`define HTR_CRC_INIT      8'h00

// Bytes in one result readout, last index
`define HTR_LAST_TX_IDX   3'h5
// Last byte index of a write with data and checksum
`define HTR_LAST_WR_BYTE  3'h5

`endif

// ==== design/htr_pkg.sv ====
/*
  Types of the humidity/temperature readout: bus-side and measurement
  state encodings.
  Assumes nothing of its surroundings.
*/
package htr_pkg;

  // Serial target states
  typedef enum logic [2:0] {
    HTR_B_IDLE,
    HTR_B_RX,
    HTR_B_ACK,
    HTR_B_TX,
    HTR_B_TXACK,
    HTR_B_TXNEXT,
    HTR_B_SKIP
  } htr_bus_e;

  // Measurement engine states
  typedef enum logic [2:0] {
    HTR_M_IDLE,
    HTR_M_CONV,
    HTR_M_PUSH_T,
    HTR_M_PUSH_H,
    HTR_M_WAIT
  } htr_meas_e;

endpackage

// ==== design/htr_sync.sv ====
/*
  Two-flop synchroniser for a group of asynchronous levels.
  Assumes one clock; the output is the second flop only.
*/
module htr_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;  // First stage, read only by the second
  logic [W-1:0] q_ff;     // Second stage

  // Two registers in series
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule

// ==== design/htr_fifo.sv ====
/*
  Result word FIFO with registered read data, valid/ready on both sides.
  Assumes one clock and synchronous active-high reset.
*/
module htr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH),
  parameter int LW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [LW-1:0]    level
);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage array
  logic [AW-1:0]    wr_ff;        // Write pointer
  logic [AW-1:0]    rd_ff;        // Read pointer
  logic [LW-1:0]    cnt_ff;       // Words held
  logic [WIDTH-1:0] dout_ff;      // Registered head word
  logic [AW-1:0]    nxt_wr;
  logic [AW-1:0]    nxt_rd;
  logic [LW-1:0]    nxt_cnt;
  logic             wr_en;
  logic             rd_en;

  assign in_ready  = (cnt_ff != LW'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = dout_ff;
  assign level     = cnt_ff;

  // Pointer and level update
  always_comb begin
    wr_en   = in_valid & in_ready;
    rd_en   = out_ready & out_valid;
    nxt_wr  = wr_en ? AW'((wr_ff + 1'b1) % DEPTH) : wr_ff;
    nxt_rd  = rd_en ? AW'((rd_ff + 1'b1) % DEPTH) : rd_ff;
    nxt_cnt = cnt_ff + LW'(wr_en) - LW'(rd_en);
  end

  // Registers; head word bypasses a write to the new head slot
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ff   <= '0;
      rd_ff   <= '0;
      cnt_ff  <= '0;
      dout_ff <= '0;
    end else begin
      wr_ff   <= nxt_wr;
      rd_ff   <= nxt_rd;
      cnt_ff  <= nxt_cnt;
      dout_ff <= (wr_en && wr_ff == nxt_rd) ? in_data : mem[nxt_rd];
      if (wr_en) begin
        mem[wr_ff] <= in_data;
      end
    end
  end

endmodule

// ==== testbench/htr_host.sv ====
/*
  Bus master model: drives scl and its share of the data line.
  Assumes a pull-up wired-AND of sda outside this module.
*/
module htr_host (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_h
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  // Wait n system clocks
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // START; also a repeated one while scl is low
  task automatic start();
    sda_h <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_h <= 1'b0;
    wt(4);
    scl <= 1'b0;
    wt(2);
  endtask
  // STOP
  task automatic stop();
    sda_h <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_h <= 1'b1;
    wt(4);
  endtask
  // One 400 ns bit; line sampled mid-high
  task automatic bitx(input logic b, output logic r);
    sda_h <= b;
    wt(2);
    scl <= 1'b1;
    wt(2);
    r = sda;
    wt(2);
    scl <= 1'b0;
    wt(2);
  endtask
  // Byte w out, m in the ninth slot, r and a back
  task automatic xfer(input logic [7:0] w, input logic m, output logic [7:0] r,
                      output logic a);
    for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
    bitx(m, a);
  endtask
endmodule

// ==== testbench/htr_readout_props.sv ====
/*
  Checker of the readout's pins.
  Assumes binding into htr_readout.
*/
module htr_chk #(
  parameter int unsigned PU_CYC = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic supply_ok,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic ready,
  input wire logic measuring,
  input wire logic periodic_mode,
  input wire logic low_power_idle
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_rdy; $rose(ready) |-> $past(supply_ok, PU_CYC); endproperty
  a_rdy: assert property (p_rdy) else $error("ready too early");
  property p_idle; low_power_idle |-> ready && !measuring; endproperty
  a_idle: assert property (p_idle) else $error("idle while busy");
  property p_od; sda_oe |-> sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data not open drain");
  property p_edge; $changed(sda_oe) |-> !$past(scl_in); endproperty
  a_edge: assert property (p_edge) else $error("data moved at high clock");
  property p_meas; $rose(measuring) && !$past(periodic_mode) |-> sda_oe; endproperty
  a_meas: assert property (p_meas) else $error("start without ack");
  property p_done; $rose(measuring) |-> ##[1:400] !measuring; endproperty
  a_done: assert property (p_done) else $error("conversion hangs");
  property p_per; periodic_mode |-> ready; endproperty
  a_per: assert property (p_per) else $error("periodic when not ready");
  property p_drv; sda_oe |-> ready; endproperty
  a_drv: assert property (p_drv) else $error("drives when not ready");
endmodule
bind htr_readout htr_chk #(.PU_CYC(PU_CYC)) i_chk (.clock(clock), .rst(rst),
  .supply_ok(supply_ok), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .ready(ready), .measuring(measuring), .periodic_mode(periodic_mode),
  .low_power_idle(low_power_idle));

// ==== testbench/tb_top.sv ====
/*
  Testbench of the readout: boot, single shot, writes, periodic, break.
  Assumes the host model and the checker are compiled first.
*/
`include "htr_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0]  DEV = 7'h2B; // Non-default target address
  localparam logic [15:0] T   = 16'h6A3C;
  localparam logic [15:0] H   = 16'h9E51;
  logic clock = 1'b0, rst = 1'b1, supply_ok = 1'b0;
  logic [15:0] temp_sample = T, hum_sample = H, wr_data;
  logic sda_out, sda_oe, ready, measuring, periodic_mode, low_power_idle, wr_valid;
  logic scl, sda_h, a, ha;
  logic [7:0] rb;
  int failures = 0, n_tests = 0, n_wrv = 0;
  wire logic sda = sda_h & ~(sda_oe & ~sda_out);
  always #25 clock = ~clock;
  always @(posedge clock) n_wrv += wr_valid;
  htr_readout #(.DEV_ADDR(DEV), .PU_CYC(20), .CONV_L_CYC(40), .CONV_M_CYC(60),
    .CONV_H_CYC(150),
    .PER4_CYC(600)) i_dut (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda),
    .supply_ok(supply_ok), .temp_sample(temp_sample), .hum_sample(hum_sample),
    .sda_out(sda_out), .sda_oe(sda_oe), .ready(ready), .measuring(measuring),
    .periodic_mode(periodic_mode), .low_power_idle(low_power_idle), .wr_data(wr_data),
    .wr_valid(wr_valid));
  htr_host i_host (.clock(clock), .sda(sda), .scl(scl), .sda_h(sda_h));
  // Command word with its folded checksum
  function automatic logic [15:0] mk(input logic [7:0] c, input logic [1:0] p,
                                      input logic [2:0] t);
    logic [15:0] w;
    w = {c, p, t, 3'h0};
    for (int i = 0; i < 13; i++) w[i % 3] ^= w[i + 3];
    return w;
  endfunction
  // Data checksum, MSB first
  function automatic logic [7:0] crc(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait for a level
  task automatic wt_lvl(ref logic s, input logic v);
    for (int i = 0; i < 999 && s !== v; i++) @(posedge clock);
    if (s !== v) begin
      failures++;
      close_out();
    end
  endtask
  // Write transfer after the spacing gap; a is the last byte's ack
  task automatic snd(input logic [7:0] q [$]);
    repeat (1500) @(posedge clock);
    i_host.start();
    foreach (q[k]) i_host.xfer(q[k], 1'b1, rb, a);
    i_host.stop();
  endtask
  task automatic cm(input logic [15:0] c);
    snd('{{DEV, 1'b0}, c[15:8], c[7:0]});
  endtask
  // Read header then n bytes, NACK on the last
  task automatic rd(input int n, output logic h);
    logic [47:0] e;
    e = {T, crc(T), H, crc(H)};
    i_host.start();
    i_host.xfer({DEV, 1'b1}, 1'b1, rb, h);
    for (int k = 0; k < n && !h; k++) begin
      i_host.xfer(8'hFF, k == n - 1, rb, a);
      chk(rb, e[47 - 8 * k -: 8]);
    end
    i_host.stop();
  endtask
  task automatic s_boot();
    cm(mk(`HTR_CLS_SINGLE, 2'h0, 3'h0));
    chk(a, 1'b1);
    supply_ok <= 1'b1;
    wt_lvl(ready, 1'b1);
  endtask
  // Each repeatability, busy refusal, wrong address, early abort
  task automatic s_single();
    for (int r = 0; r < 4; r++) begin
      cm(mk(`HTR_CLS_SINGLE, r == 3 ? 2'h0 : 2'(r), 3'h0));
      chk(a, 1'b0);
      chk(measuring, 1'b1);
      if (r == 2) rd(0, ha);
      if (r == 2) chk(ha, 1'b1);
      wt_lvl(measuring, 1'b0);
      i_host.start();
      i_host.xfer({DEV ^ 7'h01, 1'b1}, 1'b1, rb, a);
      i_host.stop();
      chk(a, 1'b1);
      rd(r == 3 ? 2 : 6, ha);
      chk(ha, 1'b0);
      rd(0, ha);
      chk(ha, 1'b1);
    end
  endtask
  // Bad command checksum, data with good and bad checksum
  task automatic s_write();
    logic [15:0] c;
    cm(mk(`HTR_CLS_SINGLE, 2'h1, 3'h0) ^ 16'h0001);
    chk(a, 1'b1);
    chk(measuring, 1'b0);
    c = mk(`HTR_CLS_BREAK, 2'h0, 3'h0);
    snd('{{DEV, 1'b0}, c[15:8], c[7:0], 8'h5A, 8'hC3, crc(16'h5AC3)});
    chk(a, 1'b0);
    chk(wr_data, 16'h5AC3);
    snd('{{DEV, 1'b0}, c[15:8], c[7:0], 8'h11, 8'h22, ~crc(16'h1122)});
    chk(a, 1'b1);
    chk(wr_data, 16'h5AC3);
    chk(n_wrv, 1);
  endtask
  // Every rate, then break and drain
  task automatic s_periodic();
    for (int t = 0; t < 5; t++) begin
      cm(mk(`HTR_CLS_PERIODIC, 2'h0, 3'(t)));
      chk(periodic_mode, 1'b1);
      cm(mk(`HTR_CLS_BREAK, 2'h0, 3'h0));
      chk(periodic_mode, 1'b0);
      chk(measuring, 1'b0);
      rd(6, ha);
      chk(ha, 1'b0);
      for (int k = 0; k < 9 && !ha; k++) rd(6, ha);
    end
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    s_boot();
    s_single();
    s_write();
    s_periodic();
    repeat (3) @(posedge clock);
    chk(low_power_idle, 1'b1);
    close_out();
  end
endmodule
